// *** hw/sensor_power_reset_sequencer.sv ***
// Host-side power, reset, clock and streaming sequencer for an image sensor
//
// Behaviour
// - PLL rail enabled first, never later
// - Rails up in order, fixed step gap
// - Input clock starts after rails settle
// - Reset held low one ms after settling
// - RC reset must cover settle times
// - Wait 160000 input clocks before access
// - Configuration written before streaming enabled
// - Wait one ms after PLL configuration
// - Clear streaming before removing any rail
// - Rails down in reverse order
// - 100 ms off before next power-up
`timescale 1ns/10ps
`default_nettype none
module sensor_power_reset_sequencer
    import sensor_seq_pkg::*;
#(
    parameter int unsigned INPUT_CLK_DIV = 10,
    parameter int unsigned RESET_CYC    = RESET_HOLD_MS * MS_CYC,
    parameter int unsigned PLL_CYC      = PLL_LOCK_MS * MS_CYC,
    parameter int unsigned OFF_GAP_CYC  = OFF_GAP_MS * MS_CYC,
    parameter int unsigned SETTLE_CYC   = RAIL_SETTLE_US * CLK_MHZ,
    parameter int unsigned INIT_CLKS    = INIT_INPUT_CLKS
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  reset_n_in,
    input  wire logic                  power_on_in,
    input  wire logic                  stream_req_in,
    input  wire logic                  config_done_in,
    input  wire logic                  soft_standby_in,
    input  wire logic                  reg_write_done_in,
    output logic [NUM_RAILS-1:0]       rail_enable_out,
    output logic                       external_input_clock_out,
    output logic                       sensor_reset_n_out,
    output logic                       config_req_out,
    output logic                       reg_write_req_out,
    output logic [15:0]                reg_write_addr_out,
    output logic                       reg_write_stream_out,
    output logic                       streaming_out,
    output logic                       powered_out
);
    import sensor_seq_pkg::*;

    if (INPUT_CLK_DIV < 2 || INPUT_CLK_DIV % 2 != 0) begin : g_div_check
        $error("Input clock divider must be even and at least 2");
    end
    if (RESET_CYC < 1 || PLL_CYC < 1 || OFF_GAP_CYC < 1 || SETTLE_CYC < 1 || INIT_CLKS < 1) begin : g_wait_check
        $error("Wait counts must be at least one");
    end

    seq_state_t       state_q;
    logic [CNT_W-1:0] cnt_q;
    logic [2:0]       rail_idx_q;
    logic [CNT_W-1:0] div_q;
    logic             clk_run_q;
    logic             clk_q;
    logic             clk_rise;
    logic             cnt_done;

    assign cnt_done = (cnt_q == '0);
    // True on the edge that drives the input clock high
    assign clk_rise = clk_run_q && !clk_q && (div_q == CNT_W'(INPUT_CLK_DIV / 2 - 1));

    // Input clock divider, gated off until rails settle
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            div_q <= '0;
            clk_q <= 1'b0;
        end else if (!clk_run_q) begin
            div_q <= '0;
            clk_q <= 1'b0;
        end else if (div_q == CNT_W'(INPUT_CLK_DIV / 2 - 1)) begin
            div_q <= '0;
            clk_q <= ~clk_q;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    // Main sequence
    always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state_q            <= ST_OFF;
            cnt_q              <= '0;
            rail_idx_q         <= '0;
            rail_enable_out    <= '0;
            clk_run_q          <= 1'b0;
            sensor_reset_n_out <= 1'b0;
            config_req_out     <= 1'b0;
            reg_write_req_out  <= 1'b0;
            reg_write_addr_out <= '0;
            reg_write_stream_out <= 1'b0;
            streaming_out      <= 1'b0;
        end else begin
            unique case (state_q)
                ST_OFF: begin
                    if (power_on_in) begin
                        rail_enable_out[RAIL_PLL] <= 1'b1;
                        rail_idx_q <= 3'h1;
                        cnt_q      <= CNT_W'(RAIL_STEP_CYC - 1);
                        state_q    <= ST_RAIL_UP;
                    end
                end
                ST_RAIL_UP: begin
                    if (cnt_done) begin
                        rail_enable_out[rail_idx_q] <= 1'b1;
                        if (rail_idx_q == 3'(NUM_RAILS - 1)) begin
                            cnt_q   <= CNT_W'(SETTLE_CYC - 1);
                            state_q <= ST_SETTLE;
                        end else begin
                            rail_idx_q <= rail_idx_q + 3'h1;
                            cnt_q      <= CNT_W'(RAIL_STEP_CYC - 1);
                        end
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_SETTLE: begin
                    if (cnt_done) begin
                        clk_run_q <= 1'b1;
                        cnt_q     <= CNT_W'(RESET_CYC - 1);
                        state_q   <= ST_RESET;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_RESET: begin
                    if (cnt_done) begin
                        sensor_reset_n_out <= 1'b1;
                        cnt_q   <= CNT_W'(INIT_CLKS - 1);
                        state_q <= ST_INIT;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_INIT: begin
                    if (clk_rise) begin
                        if (cnt_done) begin
                            config_req_out <= 1'b1;
                            state_q        <= ST_CONFIG;
                        end else begin
                            cnt_q <= cnt_q - 1'b1;
                        end
                    end
                end
                ST_CONFIG: begin
                    if (config_done_in) begin
                        config_req_out <= 1'b0;
                        cnt_q   <= CNT_W'(PLL_CYC - 1);
                        state_q <= ST_PLL_LOCK;
                    end
                end
                ST_PLL_LOCK: begin
                    if (!power_on_in && cnt_done) begin
                        state_q <= ST_STANDBY;
                    end else if (cnt_done && stream_req_in) begin
                        reg_write_req_out    <= 1'b1;
                        reg_write_addr_out   <= SENSOR_CONTROL_ADDR;
                        reg_write_stream_out <= 1'b1;
                        state_q              <= ST_STREAM_ON;
                    end else if (!cnt_done) begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_STREAM_ON: begin
                    if (reg_write_done_in) begin
                        reg_write_req_out <= 1'b0;
                        streaming_out     <= 1'b1;
                        state_q           <= ST_STREAMING;
                    end
                end
                ST_STREAMING: begin
                    if (!power_on_in || !stream_req_in) begin
                        reg_write_req_out    <= 1'b1;
                        reg_write_stream_out <= 1'b0;
                        state_q              <= ST_STREAM_OFF;
                    end
                end
                ST_STREAM_OFF: begin
                    if (reg_write_done_in) begin
                        reg_write_req_out <= 1'b0;
                        state_q           <= ST_STANDBY;
                    end
                end
                ST_STANDBY: begin
                    if (soft_standby_in) begin
                        streaming_out <= 1'b0;
                        if (!power_on_in) begin
                            clk_run_q          <= 1'b0;
                            sensor_reset_n_out <= 1'b0;
                            rail_idx_q         <= 3'(NUM_RAILS - 1);
                            cnt_q              <= CNT_W'(RAIL_STEP_CYC - 1);
                            state_q            <= ST_RAIL_DOWN;
                        end else if (stream_req_in) begin
                            reg_write_req_out    <= 1'b1;
                            reg_write_stream_out <= 1'b1;
                            state_q              <= ST_STREAM_ON;
                        end
                    end
                end
                ST_RAIL_DOWN: begin
                    if (cnt_done) begin
                        rail_enable_out[rail_idx_q] <= 1'b0;
                        cnt_q <= CNT_W'(RAIL_STEP_CYC - 1);
                        if (rail_idx_q == 3'h0) begin
                            cnt_q   <= CNT_W'(OFF_GAP_CYC - 1);
                            state_q <= ST_OFF_GAP;
                        end else begin
                            rail_idx_q <= rail_idx_q - 3'h1;
                        end
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_OFF_GAP: begin
                    if (cnt_done) begin
                        state_q <= ST_OFF;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_OFF;
                end
            endcase
        end
    end

    assign external_input_clock_out = clk_q;
    assign powered_out              = rail_enable_out[RAIL_PLL];

    localparam int STEP_SPAN = RAIL_STEP_CYC;

    sequence pll_first_s;
        $rose(rail_enable_out[RAIL_PLL]) && (rail_enable_out[NUM_RAILS-1:1] == '0);
    endsequence

    pll_first_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (rail_enable_out != '0) |-> rail_enable_out[RAIL_PLL])
        else $error("Rail on without PLL rail");

    rail_order_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        pll_first_s |-> ##[1:STEP_SPAN] rail_enable_out[RAIL_ANALOG])
        else $error("Analog rail late after PLL rail");

    clk_after_rails_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        clk_q |-> (rail_enable_out == {NUM_RAILS{1'b1}}))
        else $error("Input clock running without all rails");

    reset_hold_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        $rose(sensor_reset_n_out) |-> $past(state_q) == ST_RESET && clk_run_q)
        else $error("Reset released out of sequence");

    init_wait_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        $rose(config_req_out) |-> sensor_reset_n_out && $past(cnt_done))
        else $error("Configuration before initialization wait");

    stream_after_cfg_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        ($rose(reg_write_stream_out) && $past(state_q) == ST_PLL_LOCK) |-> $past(cnt_done))
        else $error("Streaming before PLL lock wait");

    stop_before_off_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        $fell(rail_enable_out[RAIL_SERIAL]) |-> !streaming_out && !reg_write_stream_out)
        else $error("Rail removed while streaming");

    down_order_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        $fell(rail_enable_out[RAIL_PLL]) |-> rail_enable_out[NUM_RAILS-1:1] == '0)
        else $error("PLL rail off before others");

    off_gap_a: assert property (@(posedge sys_clk_in) disable iff (!reset_n_in)
        (state_q == ST_OFF_GAP && !cnt_done) |=> rail_enable_out == '0 && state_q == ST_OFF_GAP)
        else $error("Power-up during off gap");
endmodule : sensor_power_reset_sequencer
`default_nettype wire

// *** shared/sensor_seq_pkg.sv ***
// Timing constants and state encoding for the sensor power sequencer
package sensor_seq_pkg;
    localparam int unsigned CLK_MHZ          = 200;
    localparam int unsigned RAIL_STEP_US     = 5;
    localparam int unsigned RAIL_STEP_CYC    = (RAIL_STEP_US * CLK_MHZ > 0) ? RAIL_STEP_US * CLK_MHZ : 1;
    localparam int unsigned RAIL_SETTLE_US   = 100;
    localparam int unsigned RESET_HOLD_MS    = 1;
    localparam int unsigned INIT_INPUT_CLKS  = 160000;
    localparam int unsigned PLL_LOCK_MS      = 1;
    localparam int unsigned OFF_GAP_MS       = 100;
    localparam int unsigned MS_CYC           = 1000 * CLK_MHZ;
    localparam int unsigned NUM_RAILS        = 5;
    localparam int unsigned CNT_W            = 32;
    // Rail bit positions, power-up order
    localparam int unsigned RAIL_PLL         = 0;
    localparam int unsigned RAIL_ANALOG      = 1;
    localparam int unsigned RAIL_IO          = 2;
    localparam int unsigned RAIL_CORE        = 3;
    localparam int unsigned RAIL_SERIAL      = 4;
    localparam logic [15:0] SENSOR_CONTROL_ADDR = 16'h301A;
    localparam int unsigned STREAM_BIT       = 2;

    typedef enum logic [3:0] {
        ST_OFF       = 4'h0,
        ST_RAIL_UP   = 4'h1,
        ST_SETTLE    = 4'h2,
        ST_RESET     = 4'h3,
        ST_INIT      = 4'h4,
        ST_CONFIG    = 4'h5,
        ST_PLL_LOCK  = 4'h6,
        ST_STREAM_ON = 4'h7,
        ST_STREAMING = 4'h8,
        ST_STREAM_OFF= 4'h9,
        ST_STANDBY   = 4'hA,
        ST_RAIL_DOWN = 4'hB,
        ST_OFF_GAP   = 4'hC
    } seq_state_t;
endpackage : sensor_seq_pkg

// *** testbench/sensor_model.sv ***
// Behavioural image sensor: initialization, control register and soft standby
`timescale 1ns/10ps
`default_nettype none
module sensor_model
    import sensor_seq_pkg::*;
#(
    parameter int unsigned INIT_CLKS = 8
) (
    input  wire logic                 sys_clk_in,
    input  wire logic [NUM_RAILS-1:0] rail_enable_in,
    input  wire logic                 external_input_clock_in,
    input  wire logic                 sensor_reset_n_in,
    input  wire logic                 reg_write_req_in,
    input  wire logic [15:0]          reg_write_addr_in,
    input  wire logic                 reg_write_stream_in,
    input  wire logic [7:0]           resp_cyc_in,
    input  wire logic [7:0]           row_cyc_in,
    output logic                      soft_standby_out,
    output logic                      reg_write_done_out,
    output logic                      ready_out
);
    wire logic   alive_n = sensor_reset_n_in & rail_enable_in[RAIL_PLL];
    int unsigned init_cnt;
    logic        stream_q;
    logic        pend_q;
    logic        acked_q;
    logic [7:0]  wait_q;
    logic [7:0]  row_q;
    // Internal initialization counted on the input clock
    always_ff @(posedge external_input_clock_in or negedge alive_n) begin
        if (!alive_n)
            init_cnt <= 0;
        else if (init_cnt < INIT_CLKS)
            init_cnt <= init_cnt + 1;
    end
    assign ready_out = (init_cnt >= INIT_CLKS);
    assign soft_standby_out = ready_out && !stream_q && (row_q == 8'h00);
    // Write answered after a chosen delay, then once per request
    always_ff @(posedge sys_clk_in or negedge alive_n) begin
        if (!alive_n) begin
            stream_q <= 1'b0;
            pend_q <= 1'b0;
            acked_q <= 1'b0;
            wait_q <= 8'h00;
            row_q <= 8'h00;
            reg_write_done_out <= 1'b0;
        end else begin
            reg_write_done_out <= 1'b0;
            if (!reg_write_req_in)
                acked_q <= 1'b0;
            if (row_q != 8'h00)
                row_q <= row_q - 8'h01;
            if (reg_write_req_in && !pend_q && !acked_q) begin
                pend_q <= 1'b1;
                wait_q <= resp_cyc_in;
            end else if (pend_q && wait_q != 8'h00) begin
                wait_q <= wait_q - 8'h01;
            end else if (pend_q) begin
                pend_q <= 1'b0;
                acked_q <= 1'b1;
                reg_write_done_out <= 1'b1;
                if (reg_write_addr_in == SENSOR_CONTROL_ADDR) begin
                    if (stream_q && !reg_write_stream_in)
                        row_q <= row_cyc_in;
                    stream_q <= reg_write_stream_in;
                end
            end
        end
    end
endmodule : sensor_model
`default_nettype wire

// *** testbench/sensor_power_reset_sequencer_bench.sv ***
// Self-checking bench for the sensor power and reset sequencer
`timescale 1ns/10ps
`default_nettype none
module sensor_power_reset_sequencer_bench;
    import sensor_seq_pkg::*;
    localparam int SET_C = 5, RST_C = 10, PLL_C = 10, GAP_C = 20, INIT_C = 8;
    logic sys_clk_in = 1'b0, reset_n_in = 1'b0, power_on_in = 1'b0, stream_req_in = 1'b0, config_done_in = 1'b0;
    wire logic            sb, wr_done, dev_ready;
    logic [NUM_RAILS-1:0] rails, rails_q = '0;
    logic                 ext_clk, ext_q = 1'b0, srst_n, srst_q = 1'b0, cfg_req, cfg_q = 1'b0, sb_q = 1'b0;
    logic                 wr_req, wr_q = 1'b0, wr_stream, streaming, powered, last_stream = 1'b0, sb_dn = 1'b0;
    logic [15:0]          wr_addr;
    logic [7:0]           resp_cyc = 8'h01, row_cyc = 8'h04;
    logic [31:0]          seed = 32'd26424;
    int n_mismatch = 0, comparisons = 0, cyc = 0, ext_n = 0, ext_r = 0, t_cfg = 0, t_off = -1000;
    int t_up[NUM_RAILS];
    always #2.5 sys_clk_in = ~sys_clk_in;
    sensor_power_reset_sequencer #(.RESET_CYC(RST_C), .PLL_CYC(PLL_C), .OFF_GAP_CYC(GAP_C), .SETTLE_CYC(SET_C),
        .INIT_CLKS(INIT_C)) uut (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .power_on_in(power_on_in),
        .stream_req_in(stream_req_in), .config_done_in(config_done_in), .soft_standby_in(sb),
        .reg_write_done_in(wr_done), .rail_enable_out(rails), .external_input_clock_out(ext_clk),
        .sensor_reset_n_out(srst_n), .config_req_out(cfg_req), .reg_write_req_out(wr_req),
        .reg_write_addr_out(wr_addr), .reg_write_stream_out(wr_stream), .streaming_out(streaming),
        .powered_out(powered));
    sensor_model #(.INIT_CLKS(INIT_C)) dev (.sys_clk_in(sys_clk_in), .rail_enable_in(rails),
        .external_input_clock_in(ext_clk), .sensor_reset_n_in(srst_n), .reg_write_req_in(wr_req),
        .reg_write_addr_in(wr_addr), .reg_write_stream_in(wr_stream), .resp_cyc_in(resp_cyc),
        .row_cyc_in(row_cyc), .soft_standby_out(sb), .reg_write_done_out(wr_done), .ready_out(dev_ready));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs
    function automatic int exp_up(int i);
        return i * RAIL_STEP_CYC;
    endfunction : exp_up
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    task automatic wrap_up();
        $display("Checks: %0d mismatches in %0d comparisons", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : wrap_up
    // Edge monitor on the host outputs
    always @(posedge sys_clk_in) begin
        cyc++;
        if (reset_n_in) check("powered flag", powered, rails[RAIL_PLL]);
        for (int i = 0; i < NUM_RAILS; i++) begin
            if (rails[i] && !rails_q[i]) begin
                check("reset low at rail up", srst_n, 1'b0);
                check("pll rail first", rails[RAIL_PLL], 1'b1);
                if (i == 0) begin
                    check("off gap", cyc - t_off >= GAP_C, 1'b1);
                    t_up[0] = cyc;
                    ext_n = 0;
                    ext_r = 0;
                    t_cfg = 0;
                end else begin
                    t_up[i] = cyc;
                    check("rail step", cyc - t_up[0], exp_up(i));
                end
            end
            if (!rails[i] && rails_q[i]) begin
                check("standby before rail off", sb_dn, 1'b1);
                check("stream cleared", last_stream, 1'b0);
                if (i < NUM_RAILS - 1) check("rail off order", rails[i+1], 1'b0);
                if (i == 0) t_off = cyc;
            end
        end
        if (ext_clk && !ext_q) begin
            if (ext_n == 0) check("clock after settle", rails[RAIL_SERIAL] && cyc - t_up[4] >= SET_C, 1'b1);
            ext_n++;
            if (srst_n) ext_r++;
        end
        if (srst_n && !srst_q) check("reset hold", cyc - t_up[4] >= SET_C + RST_C, 1'b1);
        // Standby as the host saw it when sensor reset fell
        if (srst_q && !srst_n) sb_dn = sb_q;
        if (cfg_req && !cfg_q) check("init clocks", ext_r >= INIT_C, 1'b1);
        if (config_done_in && t_cfg == 0) t_cfg = cyc;
        if (wr_req && !wr_q) begin
            check("write address", wr_addr, SENSOR_CONTROL_ADDR);
            check("device ready", dev_ready, 1'b1);
            if (wr_stream) check("pll lock wait", t_cfg > 0 && cyc - t_cfg >= PLL_C, 1'b1);
            last_stream = wr_stream;
        end
        {rails_q, ext_q, srst_q, cfg_q, wr_q, sb_q} = {rails, ext_clk, srst_n, cfg_req, wr_req, sb};
    end
    initial begin
        repeat (5) @(posedge sys_clk_in);
        #1 reset_n_in = 1'b1;
        for (int k = 0; k < 3; k++) begin
            resp_cyc = 8'(xs() % 40);
            row_cyc = 8'(xs() % 60);
            power_on_in = 1'b1;
            for (int n = 0; n < 20000 && !cfg_req; n++) @(posedge sys_clk_in);
            check("config request", cfg_req, 1'b1);
            repeat (xs() % 20) @(posedge sys_clk_in);
            #1 config_done_in = 1'b1;
            stream_req_in = (k != 2);
            @(posedge sys_clk_in);
            #1 config_done_in = 1'b0;
            if (k != 2) begin
                for (int n = 0; n < 400 && !streaming; n++) @(posedge sys_clk_in);
                check("streaming on", streaming, 1'b1);
                check("device streaming", sb, 1'b0);
                repeat (xs() % 50) @(posedge sys_clk_in);
                if (k == 1) begin
                    #1 stream_req_in = 1'b0;
                    for (int n = 0; n < 400 && streaming; n++) @(posedge sys_clk_in);
                    check("stream stopped", streaming, 1'b0);
                    check("device standby", sb, 1'b1);
                    #1 stream_req_in = 1'b1;
                    for (int n = 0; n < 400 && !streaming; n++) @(posedge sys_clk_in);
                    check("stream resumed", streaming, 1'b1);
                end
            end
            @(posedge sys_clk_in);
            #1 power_on_in = 1'b0;
            stream_req_in = 1'b0;
            for (int n = 0; n < 20000 && rails !== '0; n++) @(posedge sys_clk_in);
            check("rails off", rails, '0);
            check("streaming off", streaming, 1'b0);
            #1;
        end
        repeat (GAP_C + 5) @(posedge sys_clk_in);
        wrap_up();
    end
    initial begin
        #(5 * 40000);
        n_mismatch++;
        wrap_up();
    end
endmodule : sensor_power_reset_sequencer_bench
`default_nettype wire
